// [flash_clock_and_option_regs.sv]
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Operation
// - divider top bit is read-only status; low seven bits readable, written once.
// - reset clears loaded flag; first divider write sets it regardless of data.
// - erase and program blocked while loaded flag is 0, permitted once 1.
// - divider bit 6 selects bus clock direct or bus clock divided by eight.
// - flash clock is selected input divided by six-bit divisor plus one.
// - timing pulse is one flash clock period; operations count whole pulses.
// - three nonvolatile locations copied into three shadow registers every reset.
// - options shadow loaded from nonvolatile location at reset only.
// - options readable anytime, writes ignored, bits 5 to 2 read zero.
// - options bit 7 key enable, bit 6 redirect disable, bits 1:0 security.
// - security code 10 is unsecured; key or blank check success forces 10.
module flash_clock_and_option_regs
    import flash_regs_pkg::*;
(
    input wire logic pclk, // bus clock, 200 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 write
    input wire logic [15:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [7:0] nv_options, // nonvolatile options location
    input wire logic [7:0] nv_protect, // nonvolatile protection location
    input wire logic [7:0] nv_trim, // third nonvolatile location
    input wire logic op_start, // sequencer starts erase/program, pulse
    input wire logic [15:0] op_pulses, // whole timing pulses for the operation
    input wire logic backdoor_ok, // backdoor key matched, pulse
    input wire logic blank_check_ok, // blank check passed, pulse
    output logic flash_clock_tick, // one pulse per flash clock period
    output logic erase_program_enable, // operations permitted
    output logic op_busy, // operation timing in progress
    output logic op_done, // operation finished, pulse
    output logic op_rejected, // start refused while blocked, pulse
    output logic nv_loaded, // shadows hold nonvolatile values
    output logic device_unsecured, // security code is unsecured
    output logic backdoor_key_enable, // shadowed key enable
    output logic vector_redirect_disable, // shadowed redirect disable
    output logic [7:0] protect_shadow, // shadowed protection byte
    output logic [7:0] trim_shadow // shadowed third byte
);

    nv_state_type nv_state_reg;
    logic [6:0] divider_reg;
    logic loaded_reg;
    logic key_enable_reg;
    logic redirect_disable_reg;
    logic [1:0] security_reg;
    logic [PULSE_COUNT_WIDTH-1:0] remaining_reg;
    logic [31:0] read_next;
    logic addr_hit;
    logic setup_phase;
    logic access_done;
    logic divider_write;
    logic prescale_by_eight;
    logic [DIVISOR_MSB:0] divisor;
    logic pre_tick;
    logic pre_raw_tick;
    logic fclk_raw_tick;
    logic input_tick;
    logic op_accept;
    logic [7:0] options_word;

    assign prescale_by_eight = divider_reg[PRESCALE_BIT];
    assign divisor = divider_reg[DIVISOR_MSB:0];
    assign options_word = {key_enable_reg, redirect_disable_reg, OPTIONS_UNUSED, security_reg};
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign divider_write = access_done && pwrite && (paddr == CLOCK_DIVIDER_ADDR);
    assign op_accept = op_start && loaded_reg && !op_busy;

    // address decode and read mux
    always_comb begin
        addr_hit = 1'b1;
        read_next = READ_ZERO;
        case (paddr)
            CLOCK_DIVIDER_ADDR: read_next[7:0] = {loaded_reg, divider_reg};
            OPTIONS_ADDR: read_next[7:0] = options_word;
            PROTECT_ADDR: read_next[7:0] = protect_shadow;
            TRIM_ADDR: read_next[7:0] = trim_shadow;
            OP_STATUS_ADDR: begin
                read_next[BUSY_BIT] = op_busy;
                read_next[PERMIT_BIT] = loaded_reg;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    // no wait state: ready, data and error registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= READ_ZERO;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= !addr_hit;
            prdata <= pwrite ? READ_ZERO : read_next;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // write-once divider; options and shadows ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_reg <= DIVIDER_RESET;
            loaded_reg <= 1'b0;
        end else if (divider_write && !loaded_reg) begin
            divider_reg <= pwdata[DIVIDER_MSB:0];
            loaded_reg <= 1'b1;
        end
    end

    // nonvolatile capture after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_state_reg <= NV_CAPTURE;
        end else begin
            case (nv_state_reg)
                NV_CAPTURE: nv_state_reg <= NV_RUN;
                NV_RUN: nv_state_reg <= NV_RUN;
                default: nv_state_reg <= NV_CAPTURE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_shadow <= SHADOW_RESET;
            trim_shadow <= SHADOW_RESET;
            key_enable_reg <= 1'b0;
            redirect_disable_reg <= 1'b0;
            nv_loaded <= 1'b0;
        end else if (nv_state_reg == NV_CAPTURE) begin
            protect_shadow <= nv_protect;
            trim_shadow <= nv_trim;
            key_enable_reg <= nv_options[KEY_ENABLE_BIT];
            redirect_disable_reg <= nv_options[REDIRECT_DISABLE_BIT];
            nv_loaded <= 1'b1;
        end
    end

    // security code: reset capture, unlock events force unsecured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            security_reg <= ~UNSECURED_CODE;
        end else if (nv_state_reg == NV_CAPTURE) begin
            security_reg <= nv_options[SECURITY_MSB:0];
        end else if (backdoor_ok || blank_check_ok) begin
            security_reg <= UNSECURED_CODE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_unsecured <= 1'b0;
            backdoor_key_enable <= 1'b0;
            vector_redirect_disable <= 1'b0;
            erase_program_enable <= 1'b0;
        end else begin
            device_unsecured <= (security_reg == UNSECURED_CODE);
            backdoor_key_enable <= key_enable_reg;
            vector_redirect_disable <= redirect_disable_reg;
            erase_program_enable <= loaded_reg;
        end
    end

    // flash clock: optional divide by eight, then divisor plus one
    tick_divider #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .enable(loaded_reg && prescale_by_eight),
        .terminal(PRESCALE_TERMINAL),
        .tick(pre_raw_tick)
    );

    assign pre_tick = prescale_by_eight ? pre_raw_tick : 1'b1;
    assign input_tick = loaded_reg && pre_tick;

    tick_divider #(
        .WIDTH(DIVISOR_MSB + 1)
    ) u_divisor (
        .pclk(pclk),
        .presetn(presetn),
        .enable(input_tick),
        .terminal(divisor),
        .tick(fclk_raw_tick)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_clock_tick <= 1'b0;
        end else begin
            flash_clock_tick <= fclk_raw_tick;
        end
    end

    // operation timer counts whole flash clock pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_busy <= 1'b0;
            op_done <= 1'b0;
            op_rejected <= 1'b0;
            remaining_reg <= PULSE_ZERO;
        end else begin
            op_done <= 1'b0;
            op_rejected <= op_start && !loaded_reg;
            if (op_accept) begin
                if (op_pulses == PULSE_ZERO) begin
                    op_done <= 1'b1;
                end else begin
                    op_busy <= 1'b1;
                    remaining_reg <= op_pulses;
                end
            end else if (op_busy && fclk_raw_tick) begin
                remaining_reg <= remaining_reg - PULSE_ONE;
                if (remaining_reg == PULSE_ONE) begin
                    op_busy <= 1'b0;
                    op_done <= 1'b1;
                end
            end
        end
    end

    // checks
    logic [9:0] gap_reg;
    logic seen_tick_reg;
    logic [9:0] expected_gap;

    assign expected_gap = prescale_by_eight ? {1'b0, divisor, 3'h0} + 10'd8 : {4'h0, divisor} + 10'd1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= 10'h000;
            seen_tick_reg <= 1'b0;
        end else if (fclk_raw_tick) begin
            gap_reg <= 10'h001;
            seen_tick_reg <= 1'b1;
        end else if (loaded_reg) begin
            gap_reg <= gap_reg + 10'h001;
        end
    end

    sequence prescale_quiet_gap;
        !fclk_raw_tick [*7] ##1 fclk_raw_tick;
    endsequence

    sequence first_divider_write;
        divider_write && !loaded_reg;
    endsequence

    chk_loaded_on_first: assert property (@(posedge pclk) disable iff (!presetn)
        first_divider_write |=> loaded_reg && divider_reg == $past(pwdata[DIVIDER_MSB:0]))
        else $error("first divider write did not load");

    chk_divider_locked: assert property (@(posedge pclk) disable iff (!presetn)
        loaded_reg |=> loaded_reg && $stable(divider_reg))
        else $error("divider changed after first write");

    chk_divider_readback: assert property (@(posedge pclk) disable iff (!presetn)
        access_done && !pwrite && paddr == CLOCK_DIVIDER_ADDR
            |-> prdata[7:0] == {loaded_reg, divider_reg} && prdata[31:8] == 24'h000000)
        else $error("divider read mismatch");

    chk_blocked_start: assert property (@(posedge pclk) disable iff (!presetn)
        op_start && !loaded_reg |=> !op_busy && !op_done && op_rejected && !erase_program_enable)
        else $error("operation not blocked before divider load");

    chk_prescale_gap: assert property (@(posedge pclk) disable iff (!presetn)
        fclk_raw_tick && prescale_by_eight && divisor == 6'h00 |=> prescale_quiet_gap)
        else $error("prescaled flash clock not divided by eight");

    chk_flash_period: assert property (@(posedge pclk) disable iff (!presetn)
        fclk_raw_tick && seen_tick_reg |-> gap_reg == expected_gap)
        else $error("flash clock period wrong");

    chk_done_on_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(op_done) && $past(op_busy) |-> $past(fclk_raw_tick) && $past(remaining_reg) == PULSE_ONE)
        else $error("operation ended off a pulse boundary");

    chk_nv_capture: assert property (@(posedge pclk) disable iff (!presetn)
        nv_state_reg == NV_CAPTURE
            |=> protect_shadow == $past(nv_protect) && trim_shadow == $past(nv_trim) && nv_loaded)
        else $error("nonvolatile copy missed");

    chk_options_hold: assert property (@(posedge pclk) disable iff (!presetn)
        nv_state_reg == NV_RUN && !backdoor_ok && !blank_check_ok |=> $stable(options_word))
        else $error("options changed without reset or unlock");

    chk_options_read: assert property (@(posedge pclk) disable iff (!presetn)
        access_done && !pwrite && paddr == OPTIONS_ADDR
            |-> prdata[5:2] == OPTIONS_UNUSED && prdata[7:0] == $past(options_word))
        else $error("options read wrong");

    chk_option_fields: assert property (@(posedge pclk) disable iff (!presetn)
        nv_state_reg == NV_RUN |-> ##1 backdoor_key_enable == $past(options_word[KEY_ENABLE_BIT])
            && vector_redirect_disable == $past(options_word[REDIRECT_DISABLE_BIT]))
        else $error("option field outputs wrong");

    chk_unlock_event: assert property (@(posedge pclk) disable iff (!presetn)
        nv_state_reg == NV_RUN && (backdoor_ok || blank_check_ok)
            |=> security_reg == UNSECURED_CODE ##1 device_unsecured)
        else $error("unlock did not unsecure");

    chk_zero_pulse_done: assert property (@(posedge pclk) disable iff (!presetn)
        op_accept && op_pulses == PULSE_ZERO |=> op_done && !op_busy)
        else $error("zero-pulse operation did not finish at once");

    chk_busy_on_accept: assert property (@(posedge pclk) disable iff (!presetn)
        op_accept && op_pulses != PULSE_ZERO |=> op_busy && remaining_reg == $past(op_pulses))
        else $error("accepted operation not started");

    chk_enable_follows: assert property (@(posedge pclk) disable iff (!presetn)
        loaded_reg |=> erase_program_enable)
        else $error("erase and program not enabled after load");

    chk_rejected_cause: assert property (@(posedge pclk) disable iff (!presetn)
        op_rejected |-> $past(op_start) && !$past(loaded_reg))
        else $error("operation refused without cause");

    chk_security_capture: assert property (@(posedge pclk) disable iff (!presetn)
        nv_state_reg == NV_CAPTURE |=> security_reg == $past(nv_options[SECURITY_MSB:0])
            && redirect_disable_reg == $past(nv_options[REDIRECT_DISABLE_BIT]))
        else $error("options not captured at reset");

    chk_direct_feed: assert property (@(posedge pclk) disable iff (!presetn)
        loaded_reg && !prescale_by_eight && divisor == 6'h00 |-> fclk_raw_tick)
        else $error("undivided flash clock missed a cycle");

    chk_ready_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");

    chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        access_done && !addr_hit |-> pslverr && prdata == READ_ZERO)
        else $error("unmapped access not flagged");

endmodule : flash_clock_and_option_regs

// [flash_regs_pkg.sv]
package flash_regs_pkg;

    // register indices; one aligned word each, byte address is four times the index
    localparam logic [13:0] CLOCK_DIVIDER_INDEX = 14'h1820;
    localparam logic [13:0] OPTIONS_INDEX = 14'h1821;
    localparam logic [13:0] PROTECT_INDEX = 14'h1828;
    localparam logic [13:0] TRIM_INDEX = 14'h1829;
    localparam logic [13:0] OP_STATUS_INDEX = 14'h182A;

    // register byte addresses on the APB bus
    localparam logic [15:0] CLOCK_DIVIDER_ADDR = {CLOCK_DIVIDER_INDEX, 2'h0};
    localparam logic [15:0] OPTIONS_ADDR = {OPTIONS_INDEX, 2'h0};
    localparam logic [15:0] PROTECT_ADDR = {PROTECT_INDEX, 2'h0};
    localparam logic [15:0] TRIM_ADDR = {TRIM_INDEX, 2'h0};
    localparam logic [15:0] OP_STATUS_ADDR = {OP_STATUS_INDEX, 2'h0};

    // clock divider fields
    localparam int LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int DIVISOR_MSB = 5;
    localparam int DIVIDER_MSB = 6;
    localparam logic [6:0] DIVIDER_RESET = 7'h00;

    // options fields
    localparam int KEY_ENABLE_BIT = 7;
    localparam int REDIRECT_DISABLE_BIT = 6;
    localparam int SECURITY_MSB = 1;
    localparam logic [3:0] OPTIONS_UNUSED = 4'h0;
    localparam logic [1:0] UNSECURED_CODE = 2'h2;
    localparam logic [7:0] SHADOW_RESET = 8'h00;

    // operation status fields
    localparam int BUSY_BIT = 0;
    localparam int PERMIT_BIT = 1;

    // prescaler: divide by eight, counter terminal seven
    localparam int PRESCALE_WIDTH = 3;
    localparam logic [2:0] PRESCALE_TERMINAL = 3'h7;
    localparam int PRESCALE_RATIO = 8;

    localparam int PULSE_COUNT_WIDTH = 16;
    localparam logic [15:0] PULSE_ONE = 16'h0001;
    localparam logic [15:0] PULSE_ZERO = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [0:0] {
        NV_CAPTURE = 1'b0,
        NV_RUN = 1'b1
    } nv_state_type;

endpackage : flash_regs_pkg

// [test_flash_clock_and_option_regs.sv]
`timescale 1ns/1ps
module test_flash_clock_and_option_regs;
    import flash_regs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, op_start, backdoor_ok, blank_check_ok;
    logic [15:0] paddr, op_pulses;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, flash_clock_tick, erase_program_enable, op_busy, op_done, op_rejected, err;
    logic nv_loaded, device_unsecured, backdoor_key_enable, vector_redirect_disable;
    logic [7:0] nv_options, nv_protect, nv_trim, protect_shadow, trim_shadow;
    int fail_count = 0;
    int checked = 0;
    int period;

    flash_clock_and_option_regs i_flash_clock_and_option_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nv_options(nv_options), .nv_protect(nv_protect), .nv_trim(nv_trim),
        .op_start(op_start), .op_pulses(op_pulses), .backdoor_ok(backdoor_ok),
        .blank_check_ok(blank_check_ok), .flash_clock_tick(flash_clock_tick),
        .erase_program_enable(erase_program_enable), .op_busy(op_busy), .op_done(op_done),
        .op_rejected(op_rejected), .nv_loaded(nv_loaded), .device_unsecured(device_unsecured),
        .backdoor_key_enable(backdoor_key_enable), .vector_redirect_disable(vector_redirect_disable),
        .protect_shadow(protect_shadow), .trim_shadow(trim_shadow)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare

    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // one apb transfer, entered just after a rising edge; ends one idle edge later
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // edges between two flash clock ticks
    task automatic measure(output int p);
        int c;
        c = 0;
        while (flash_clock_tick !== 1'b1 && c < 200) begin
            @(posedge pclk);
            c++;
        end
        p = 0;
        do begin
            @(posedge pclk);
            p++;
        end while (flash_clock_tick !== 1'b1 && p < 200);
    endtask : measure

    task automatic start_op(input logic [15:0] n, input logic ok);
        int c;
        int lo;
        int hi;
        lo = (n == 16'h0000) ? 0 : (int'(n) - 1) * period + 1;
        hi = int'(n) * period;
        op_start <= 1'b1;
        op_pulses <= n;
        @(posedge pclk);
        op_start <= 1'b0;
        @(posedge pclk);
        compare(op_rejected, !ok);
        compare(op_busy, ok && n != 16'h0000);
        if (ok) begin
            c = 0;
            while (op_done !== 1'b1 && c < 2000) begin
                @(posedge pclk);
                c++;
            end
            compare(c >= lo && c <= hi, 1'b1);
        end
    endtask : start_op

    initial begin
        logic [7:0] nvo;
        logic [31:0] w;
        logic [7:0] div_exp;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        op_start = 1'b0;
        op_pulses = 16'h0000;
        backdoor_ok = 1'b0;
        blank_check_ok = 1'b0;
        nv_options = 8'h00;
        nv_protect = 8'h00;
        nv_trim = 8'h00;
        void'($urandom(93374));
        for (int r = 0; r < 4; r++) begin
            nvo = 8'($urandom());
            if (r < 2) nvo[1:0] = 2'b01;
            presetn <= 1'b0;
            nv_options <= nvo;
            nv_protect <= 8'($urandom());
            nv_trim <= 8'($urandom());
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            repeat (3) @(posedge pclk);
            compare(nv_loaded, 1'b1);
            compare(protect_shadow, nv_protect);
            compare(trim_shadow, nv_trim);
            compare(backdoor_key_enable, nvo[7]);
            compare(vector_redirect_disable, nvo[6]);
            compare(device_unsecured, nvo[1:0] == 2'b10);
            nv_options <= ~nvo;
            apb(1'b1, OPTIONS_ADDR, 32'hFFFF_FFFF);
            apb(1'b0, OPTIONS_ADDR, 32'h0000_0000);
            compare(rd, {24'h000000, nvo[7:6], 4'h0, nvo[1:0]});
            apb(1'b0, PROTECT_ADDR, 32'h0000_0000);
            compare(rd, {24'h000000, nv_protect});
            apb(1'b0, TRIM_ADDR, 32'h0000_0000);
            compare(rd, {24'h000000, nv_trim});
            apb(1'b0, CLOCK_DIVIDER_ADDR, 32'h0000_0000);
            compare(rd, 32'h0000_0000);
            compare(erase_program_enable, 1'b0);
            start_op(16'h0001, 1'b0);
            w = $urandom();
            if (r == 0) w[7:0] = 8'h80;
            else if (r == 1) w[7:0] = 8'h47;
            else w[5:3] = 3'h0;
            div_exp = {1'b1, w[6:0]};
            // a 200 MHz bus cannot reach the flash clock band; short ratios keep the run brief
            apb(1'b1, CLOCK_DIVIDER_ADDR, w);
            apb(1'b0, CLOCK_DIVIDER_ADDR, 32'h0000_0000);
            compare(rd, div_exp);
            compare(erase_program_enable, 1'b1);
            apb(1'b1, CLOCK_DIVIDER_ADDR, ~w);
            apb(1'b0, CLOCK_DIVIDER_ADDR, 32'h0000_0000);
            compare(rd, div_exp);
            measure(period);
            compare(period, (w[6] ? 8 : 1) * (w[5:0] + 1));
            start_op(16'(1 + r % 3), 1'b1);
            start_op(16'h0000, 1'b1);
            apb(1'b0, OP_STATUS_ADDR, 32'h0000_0000);
            compare(rd, 32'h0000_0002);
            apb(1'b0, 16'h1840, 32'h0000_0000);
            compare({err, rd[30:0]}, 32'h8000_0000);
            backdoor_ok <= ~r[0];
            blank_check_ok <= r[0];
            @(posedge pclk);
            backdoor_ok <= 1'b0;
            blank_check_ok <= 1'b0;
            repeat (3) @(posedge pclk);
            compare(device_unsecured, 1'b1);
            apb(1'b0, OPTIONS_ADDR, 32'h0000_0000);
            compare(rd[1:0], UNSECURED_CODE);
        end
        complete_run();
    end

    // cuts a hang well beyond the expected run length
    initial begin
        #300000;
        fail_count++;
        complete_run();
    end
endmodule : test_flash_clock_and_option_regs

// [tick_divider.sv]
`timescale 1ns/1ps
module tick_divider #(
    parameter int WIDTH = 6
) (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic enable, // advance one step
    input wire logic [WIDTH-1:0] terminal, // divide by terminal plus one
    output logic tick // one-cycle pulse at terminal
);

    logic [WIDTH-1:0] count_reg;

    assign tick = enable && (count_reg >= terminal);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= '0;
        end else if (enable) begin
            count_reg <= count_reg + 1'b1;
        end
    end

endmodule : tick_divider
